/* File: design/ssr_flash_dev.sv */
// Flash end: security register erase, program, read and software reset.
// Assumes link pins are asynchronous to pclk; status logic lives outside.
//
// How it works
// - Three 256-byte registers, individually erased, programmed
// - Erase accepted only with write enable latch set
// - Erase frame is 44h plus 24-bit address
// - Address 00h, bits 15:12 pick register, 11:8 zero
// - Erase runs only if frame ends right after the 32nd bit
// - Erase self-timed, busy high throughout, reads refused
// - Erase completion clears write enable latch
// - Locked register ignores erase; lock bits permanent
// - Locked register ignores program
// - Program 42h writes one to 256 bytes
// - Program accepted only with write enable latch set
// - Host holds select low through all data
// - Read is 48h, address, eight dummy clocks
// - Sample on rising, drive output on falling, MSB first
// - Read address increments, wraps FFh to 00h
// - Read while busy ignored, cycle undisturbed
// - Accepted reset aborts work, clears volatile state
// - Reset needs 66h immediately followed by 99h
// - Other command after 66h cancels reset enable
// - About 30us reset time, all commands refused
// - Host should check busy and suspend first
`timescale 1ns/1ps
`default_nettype none
module ssr_flash_dev #(
  parameter int ERASE_CYCLES = ssr_pkg::SSR_ERASE_CYCLES_DEF,
  parameter int PROG_CYCLES = ssr_pkg::SSR_PROG_CYCLES_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  ssr_link_if.dev link,
  input wire logic [2:0] otp_lock_bits,
  input wire logic write_enable_latch,
  input wire logic ext_busy,
  output logic busy,
  output logic wel_clear,
  output logic sw_reset
);
  import ssr_pkg::*;

  // ==========================================================
  // Pin synchronisers
  logic [2:0] cs_sq, cs_sd;
  logic [2:0] sck_sq, sck_sd;
  logic [1:0] mosi_sq, mosi_sd;

  // Shift pins in; stage 2 is only an edge reference
  always_comb begin
    cs_sd = {cs_sq[1:0], link.cs_n};
    sck_sd = {sck_sq[1:0], link.sck};
    mosi_sd = {mosi_sq[0], link.mosi};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_sq <= 3'h7;
      sck_sq <= 3'h0;
      mosi_sq <= 2'h0;
    end else begin
      cs_sq <= cs_sd;
      sck_sq <= sck_sd;
      mosi_sq <= mosi_sd;
    end
  end

  logic cs_low, cs_fall, cs_rise, sck_rise, sck_fall, din;
  assign cs_low = ~cs_sq[1];
  assign cs_fall = ~cs_sq[1] & cs_sq[2];
  assign cs_rise = cs_sq[1] & ~cs_sq[2];
  assign sck_rise = sck_sq[1] & ~sck_sq[2] & cs_low;
  assign sck_fall = ~sck_sq[1] & sck_sq[2] & cs_low;
  assign din = mosi_sq[1];

  // ==========================================================
  // Storage
  logic [7:0] mem [0:SSR_NREG*SSR_REG_BYTES-1];
  logic mem_we;
  logic [9:0] mem_idx;
  logic [7:0] mem_wd;

  always_ff @(posedge pclk) begin
    if (mem_we) mem[mem_idx] <= mem_wd;
  end

  // ==========================================================
  // Frame decode
  ssr_op_t st_q, st_d;
  logic [5:0] cnt_q, cnt_d;
  logic [7:0] op_q, op_d, osh_q, osh_d;
  logic [23:0] addr_q, addr_d;
  logic [1:0] sel_q, sel_d;
  logic act_q, act_d, rst_en_q, rst_en_d, miso_q, miso_d, oe_q, oe_d;
  logic go_reset, go_erase, go_prog, p_we;
  logic [7:0] inb, p_wd;
  logic [1:0] asel;
  logic busy_now, refuse;

  assign busy_now = (st_q != SSR_IDLE) | ext_busy;
  assign refuse = (st_q == SSR_RESET);
  assign inb = {osh_q[6:0], din};

  always_comb begin
    cnt_d = cnt_q;
    op_d = op_q;
    osh_d = osh_q;
    addr_d = addr_q;
    sel_d = sel_q;
    act_d = act_q;
    rst_en_d = rst_en_q;
    miso_d = miso_q;
    oe_d = oe_q;
    go_reset = 1'b0;
    go_erase = 1'b0;
    go_prog = 1'b0;
    p_we = 1'b0;
    p_wd = 8'h00;
    asel = ssr_sel({addr_q[22:0], din});
    if (cs_fall) begin
      cnt_d = 6'h00;
      act_d = 1'b0;
      oe_d = 1'b0;
    end else if (sck_rise) begin
      // Bit count holds inside the data field, one lap per byte
      cnt_d = (cnt_q == SSR_DATA_LAST) ? SSR_DATA_START : cnt_q + 6'h01;
      if (cnt_q <= SSR_OP_LAST) op_d = {op_q[6:0], din};
      else if (cnt_q <= SSR_ADDR_LAST) addr_d = {addr_q[22:0], din};
      if (!(act_q && op_q == SSR_OP_READ && cnt_q >= SSR_DATA_START)) osh_d = inb;
      if (cnt_q == SSR_OP_LAST && !refuse) begin
        rst_en_d = ({op_q[6:0], din} == SSR_OP_RST_EN);
        go_reset = rst_en_q && ({op_q[6:0], din} == SSR_OP_RST);
      end
      if (cnt_q == SSR_ADDR_LAST) begin
        sel_d = asel;
        if (op_q == SSR_OP_READ)
          act_d = !busy_now && asel != SSR_SEL_BAD;
        else if (op_q == SSR_OP_PROG)
          act_d = !busy_now && write_enable_latch && asel != SSR_SEL_BAD
                  && !otp_lock_bits[asel];
      end
      if (cnt_q[2:0] == 3'h7 && cnt_q >= SSR_DUMMY_LAST && act_q) begin
        if (op_q == SSR_OP_READ) begin
          // Next byte out, pointer wraps inside the register
          osh_d = mem[{sel_q, addr_q[7:0]}];
          addr_d[7:0] = addr_q[7:0] + 8'h01;
        end else if (op_q == SSR_OP_PROG) begin
          // Flash cells only clear bits
          p_we = 1'b1;
          p_wd = mem[{sel_q, addr_q[7:0]}] & inb;
          addr_d[7:0] = addr_q[7:0] + 8'h01;
        end
      end
    end else if (sck_fall && act_q && op_q == SSR_OP_READ && cnt_q >= SSR_DATA_START) begin
      miso_d = osh_q[7];
      osh_d = {osh_q[6:0], 1'b0};
      oe_d = 1'b1;
    end else if (cs_rise) begin
      act_d = 1'b0;
      oe_d = 1'b0;
      // Erase only on an exact 32-bit frame
      go_erase = op_q == SSR_OP_ERASE && cnt_q == SSR_ADDR_END && !busy_now
                 && write_enable_latch && ssr_sel(addr_q) != SSR_SEL_BAD
                 && !otp_lock_bits[ssr_sel(addr_q)];
      go_prog = act_q && op_q == SSR_OP_PROG && cnt_q == SSR_DATA_START;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 6'h00;
      op_q <= 8'h00;
      osh_q <= 8'h00;
      addr_q <= 24'h00_0000;
      sel_q <= SSR_SEL_BAD;
      act_q <= 1'b0;
      rst_en_q <= 1'b0;
      miso_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      op_q <= op_d;
      osh_q <= osh_d;
      addr_q <= addr_d;
      sel_q <= sel_d;
      act_q <= act_d;
      rst_en_q <= rst_en_d;
      miso_q <= miso_d;
      oe_q <= oe_d;
    end
  end

  assign link.miso = miso_q;
  assign link.miso_oe = oe_q;

  // ==========================================================
  // Internal operation sequencer
  logic [15:0] tmr_q, tmr_d;
  logic [1:0] esel_q, esel_d;
  logic busy_d, wel_clear_d, sw_reset_d;

  always_comb begin
    st_d = st_q;
    tmr_d = tmr_q + 16'h0001;
    esel_d = esel_q;
    wel_clear_d = 1'b0;
    sw_reset_d = 1'b0;
    mem_we = p_we;
    mem_idx = {sel_q, addr_q[7:0]};
    mem_wd = p_wd;
    case (st_q)
      SSR_IDLE: begin
        tmr_d = 16'h0000;
        if (go_erase) begin
          st_d = SSR_ERASE;
          esel_d = ssr_sel(addr_q);
        end else if (go_prog) begin
          st_d = SSR_PROG;
        end
      end
      SSR_ERASE: begin
        // One byte to all ones per cycle over the first 256 cycles
        if (tmr_q < 16'(SSR_REG_BYTES)) begin
          mem_we = 1'b1;
          mem_idx = {esel_q, tmr_q[7:0]};
          mem_wd = 8'hff;
        end
        if (tmr_q == 16'(ERASE_CYCLES - 1)) begin
          st_d = SSR_IDLE;
          wel_clear_d = 1'b1;
        end
      end
      SSR_PROG: begin
        if (tmr_q == 16'(PROG_CYCLES - 1)) begin
          st_d = SSR_IDLE;
          wel_clear_d = 1'b1;
        end
      end
      SSR_RESET: begin
        if (tmr_q == 16'(SSR_RST_CYCLES - 1)) st_d = SSR_IDLE;
      end
      default: st_d = SSR_IDLE;
    endcase
    // Reset wins over everything in flight
    if (go_reset) begin
      st_d = SSR_RESET;
      tmr_d = 16'h0000;
      sw_reset_d = 1'b1;
      wel_clear_d = 1'b1;
    end
    busy_d = (st_d != SSR_IDLE);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= SSR_IDLE;
      tmr_q <= 16'h0000;
      esel_q <= 2'h0;
      busy <= 1'b0;
      wel_clear <= 1'b0;
      sw_reset <= 1'b0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      esel_q <= esel_d;
      busy <= busy_d;
      wel_clear <= wel_clear_d;
      sw_reset <= sw_reset_d;
    end
  end

endmodule
`default_nettype wire

/* File: shared/ssr_pkg.sv */
// Constants, types and decode helpers shared by both link ends.
// Assumes both ends run from pclk at 40 MHz.
package ssr_pkg;

  // ==========================================================
  // Opcodes
  localparam logic [7:0] SSR_OP_ERASE = 8'h44;
  localparam logic [7:0] SSR_OP_PROG = 8'h42;
  localparam logic [7:0] SSR_OP_READ = 8'h48;
  localparam logic [7:0] SSR_OP_RST_EN = 8'h66;
  localparam logic [7:0] SSR_OP_RST = 8'h99;

  // ==========================================================
  // Address layout and frame bit counts
  localparam logic [7:0] SSR_ADDR_HI = 8'h00;
  localparam logic [3:0] SSR_ADDR_MID = 4'h0;
  localparam logic [3:0] SSR_SEL1 = 4'h4;
  localparam logic [3:0] SSR_SEL2 = 4'h8;
  localparam logic [3:0] SSR_SEL3 = 4'hc;
  localparam logic [1:0] SSR_SEL_BAD = 2'h3;
  localparam int SSR_NREG = 3;
  localparam int SSR_REG_BYTES = 256;
  localparam logic [5:0] SSR_OP_LAST = 6'h07;
  localparam logic [5:0] SSR_ADDR_LAST = 6'h1f;
  localparam logic [5:0] SSR_ADDR_END = 6'h20;
  localparam logic [5:0] SSR_DUMMY_LAST = 6'h27;
  localparam logic [5:0] SSR_DATA_START = 6'h28;
  localparam logic [5:0] SSR_DATA_LAST = 6'h2f;

  // ==========================================================
  // Timing
  localparam int SSR_CLK_NS = 25;
  localparam int SSR_RST_NS = 30000;
  localparam int SSR_RST_CYCLES = (SSR_RST_NS + SSR_CLK_NS - 1) / SSR_CLK_NS;
  localparam int SSR_ERASE_CYCLES_DEF = 2000;
  localparam int SSR_PROG_CYCLES_DEF = 400;
  localparam int SSR_SCK_HALF_DEF = 8;

  // ==========================================================
  // Controller register map and fields
  localparam logic [7:0] SSR_R_CTRL = 8'h00;
  localparam logic [7:0] SSR_R_ADDR = 8'h04;
  localparam logic [7:0] SSR_R_TXD = 8'h08;
  localparam logic [7:0] SSR_R_RXD = 8'h0c;
  localparam logic [7:0] SSR_R_STAT = 8'h10;
  localparam int SSR_F_SEND_OP = 8;
  localparam int SSR_F_SEND_ADDR = 9;
  localparam int SSR_F_SEND_DUMMY = 10;
  localparam int SSR_F_NBYTES = 11;
  localparam int SSR_F_HOLD_CS = 14;
  localparam int SSR_F_START = 31;
  localparam logic [31:0] SSR_CTRL_RST = 32'h0000_0000;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    SSR_IDLE = 2'b00,
    SSR_ERASE = 2'b01,
    SSR_PROG = 2'b10,
    SSR_RESET = 2'b11
  } ssr_op_t;

  typedef enum logic [1:0] {
    SSR_H_IDLE = 2'b00,
    SSR_H_RUN = 2'b01,
    SSR_H_GAP = 2'b10
  } ssr_hst_t;

  // Register select from a 24-bit address, SSR_SEL_BAD if none
  function automatic logic [1:0] ssr_sel(input logic [23:0] a);
    logic [1:0] s;
    s = SSR_SEL_BAD;
    if (a[23:16] == SSR_ADDR_HI && a[11:8] == SSR_ADDR_MID) begin
      if (a[15:12] == SSR_SEL1) s = 2'h0;
      else if (a[15:12] == SSR_SEL2) s = 2'h1;
      else if (a[15:12] == SSR_SEL3) s = 2'h2;
    end
    return s;
  endfunction

endpackage

/* File: shared/ssr_link_if.sv */
// Serial link between controller and flash security-register logic.
// Assumes the bench resolves miso from miso_oe.
`timescale 1ns/1ps
`default_nettype none
interface ssr_link_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic miso;
  logic miso_oe;
  modport dev (input cs_n, input sck, input mosi, output miso, output miso_oe);
  modport host (output cs_n, output sck, output mosi, input miso, input miso_oe);
endinterface
`default_nettype wire

/* File: design/ssr_host_ctrl.sv */
// Controller end: APB-programmed frame engine that drives the link.
// Assumes an APB master on pclk; miso is asynchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module ssr_host_ctrl #(
  parameter int SCK_HALF = ssr_pkg::SSR_SCK_HALF_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  ssr_link_if.host link
);
  import ssr_pkg::*;

  // ==========================================================
  // Register bus, one wait state per access
  logic [31:0] ctrl_q, ctrl_d, addr_q, addr_d, txd_q, txd_d, rxd_q, rxd_d;
  logic [31:0] prdata_d;
  logic pready_d, pslverr_d, hit, wr_fire, start;
  ssr_hst_t st_q, st_d;
  logic [71:0] sh_q, sh_d;
  logic [6:0] left_q, left_d;
  logic [15:0] div_q, div_d;
  logic cs_q, cs_d, sck_q, sck_d, mosi_q, mosi_d;
  logic [1:0] miso_sq;

  assign hit = paddr == SSR_R_CTRL || paddr == SSR_R_ADDR || paddr == SSR_R_TXD
               || paddr == SSR_R_RXD || paddr == SSR_R_STAT;
  assign wr_fire = psel && penable && pready && pwrite && hit;
  // Start is refused while a frame runs
  assign start = wr_fire && paddr == SSR_R_CTRL && pwdata[SSR_F_START] && st_q == SSR_H_IDLE;

  always_comb begin
    pready_d = psel && penable && !pready;
    pslverr_d = psel && penable && !pready && !hit;
    prdata_d = prdata;
    if (psel && penable && !pready) begin
      if (paddr == SSR_R_CTRL) prdata_d = ctrl_q;
      else if (paddr == SSR_R_ADDR) prdata_d = addr_q;
      else if (paddr == SSR_R_TXD) prdata_d = txd_q;
      else if (paddr == SSR_R_RXD) prdata_d = rxd_q;
      else if (paddr == SSR_R_STAT) prdata_d = {30'h0, ~cs_q, st_q != SSR_H_IDLE};
      else prdata_d = 32'h0000_0000;
    end
    ctrl_d = ctrl_q;
    addr_d = addr_q;
    txd_d = txd_q;
    if (wr_fire && st_q == SSR_H_IDLE) begin
      if (paddr == SSR_R_CTRL) ctrl_d = {1'b0, pwdata[30:0]};
      else if (paddr == SSR_R_ADDR) addr_d = {8'h00, pwdata[23:0]};
      else if (paddr == SSR_R_TXD) txd_d = pwdata;
    end
  end

  // ==========================================================
  // Frame engine: bits packed MSB first, clock divided from pclk
  always_comb begin
    logic [6:0] n;
    logic [71:0] v;
    n = 7'h00;
    v = 72'h0;
    st_d = st_q;
    sh_d = sh_q;
    left_d = left_q;
    div_d = div_q + 16'h0001;
    cs_d = cs_q;
    sck_d = sck_q;
    mosi_d = mosi_q;
    rxd_d = rxd_q;
    case (st_q)
      SSR_H_IDLE: begin
        div_d = 16'h0000;
        if (start) begin
          if (pwdata[SSR_F_SEND_OP]) begin
            v = {v[63:0], pwdata[7:0]};
            n = n + 7'd8;
          end
          if (pwdata[SSR_F_SEND_ADDR]) begin
            v = {v[47:0], addr_q[23:0]};
            n = n + 7'd24;
          end
          if (pwdata[SSR_F_SEND_DUMMY]) begin
            v = {v[63:0], 8'h00};
            n = n + 7'd8;
          end
          for (int k = 0; k < 4; k++) begin
            if (3'(k) < pwdata[SSR_F_NBYTES +: 3]) begin
              v = {v[63:0], txd_q[31 - 8 * k -: 8]};
              n = n + 7'd8;
            end
          end
          sh_d = v << (7'd72 - n);
          left_d = n;
          cs_d = 1'b0;
          mosi_d = v[7'(n - 7'd1)];
          st_d = SSR_H_RUN;
        end
      end
      SSR_H_RUN: begin
        if (div_q == 16'(SCK_HALF - 1)) begin
          div_d = 16'h0000;
          if (left_q == 7'h00 && !sck_q) begin
            // Select rises half an sck period after the last falling edge, unless SSR_F_HOLD_CS is set
            cs_d = ~ctrl_q[SSR_F_HOLD_CS];
            st_d = ctrl_q[SSR_F_HOLD_CS] ? SSR_H_IDLE : SSR_H_GAP;
          end else if (!sck_q) begin
            sck_d = 1'b1;
            rxd_d = {rxd_q[30:0], miso_sq[1]};
            left_d = left_q - 7'h01;
          end else begin
            sck_d = 1'b0;
            sh_d = {sh_q[70:0], 1'b0};
            mosi_d = sh_q[70];
          end
        end
      end
      SSR_H_GAP: begin
        if (div_q == 16'(SCK_HALF - 1)) st_d = SSR_H_IDLE;
      end
      default: st_d = SSR_H_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= SSR_CTRL_RST;
      addr_q <= 32'h0000_0000;
      txd_q <= 32'h0000_0000;
      rxd_q <= 32'h0000_0000;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      st_q <= SSR_H_IDLE;
      sh_q <= 72'h0;
      left_q <= 7'h00;
      div_q <= 16'h0000;
      cs_q <= 1'b1;
      sck_q <= 1'b0;
      mosi_q <= 1'b0;
      miso_sq <= 2'h0;
    end else begin
      ctrl_q <= start ? {1'b0, pwdata[30:0]} : ctrl_d;
      addr_q <= addr_d;
      txd_q <= txd_d;
      rxd_q <= rxd_d;
      prdata <= prdata_d;
      pready <= pready_d;
      pslverr <= pslverr_d;
      st_q <= st_d;
      sh_q <= sh_d;
      left_q <= left_d;
      div_q <= div_d;
      cs_q <= cs_d;
      sck_q <= sck_d;
      mosi_q <= mosi_d;
      miso_sq <= {miso_sq[0], link.miso};
    end
  end

  assign link.cs_n = cs_q;
  assign link.sck = sck_q;
  assign link.mosi = mosi_q;

endmodule
`default_nettype wire

/* File: verif/ssr_link_monitor.sv */
// Checker on the serial link and the flash end status outputs.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/1ps
`default_nettype none
module ssr_link_monitor
  import ssr_pkg::*;
#(
  parameter int ERASE_CYCLES = 2000,
  parameter int PROG_CYCLES = 400
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic busy,
  input wire logic wel_clear,
  input wire logic sw_reset
);
  logic busy_q, busy_d, sck_q, sck_d, rst_q, rst_d, fb_q, fb_d;
  logic [5:0] nbit_q, nbit_d;
  logic [15:0] bcnt_q, bcnt_d;

  // ==========================================================
  // Helper state
  // Busy run length, reset run, sck rises in frame, busy at opcode
  always_comb begin
    busy_d = busy;
    sck_d = sck;
    rst_d = sw_reset | (rst_q & ~(busy_q & ~busy));
    bcnt_d = busy ? bcnt_q + 16'h1 : 16'h0;
    nbit_d = nbit_q;
    if (cs_n) nbit_d = 6'h00;
    else if (sck & ~sck_q & (nbit_q != 6'h3f)) nbit_d = nbit_q + 6'h01;
    fb_d = ~cs_n & (fb_q | ((nbit_q == 6'h09) & busy));
  end

  // Helper registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      sck_q <= 1'b0;
      rst_q <= 1'b0;
      fb_q <= 1'b0;
      nbit_q <= 6'h00;
      bcnt_q <= 16'h0000;
    end else begin
      busy_q <= busy_d;
      sck_q <= sck_d;
      rst_q <= rst_d;
      fb_q <= fb_d;
      nbit_q <= nbit_d;
      bcnt_q <= bcnt_d;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_sck_idle;
    cs_n |-> !sck;
  endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("sck high while deselected");
  property p_mosi_stable;
    !cs_n && $changed(mosi) |-> !sck;
  endproperty
  a_mosi_stable: assert property (p_mosi_stable) else $error("mosi moved with sck high");
  property p_miso_fall;
    miso_oe && $past(miso_oe) && $changed(miso) |-> !sck;
  endproperty
  a_miso_fall: assert property (p_miso_fall) else $error("miso moved with sck high");
  property p_oe_start;
    $rose(miso_oe) |-> nbit_q == 6'h28;
  endproperty
  a_oe_start: assert property (p_oe_start) else $error("read data not after 40 bits");
  property p_oe_release;
    $rose(cs_n) |-> ##[1:8] !miso_oe;
  endproperty
  a_oe_release: assert property (p_oe_release) else $error("miso kept after deselect");
  property p_read_busy;
    fb_q |-> !miso_oe;
  endproperty
  a_read_busy: assert property (p_read_busy) else $error("read served while busy");
  property p_wel_done;
    busy_q && !busy && !rst_q |-> wel_clear;
  endproperty
  a_wel_done: assert property (p_wel_done) else $error("no latch clear at cycle end");
  property p_busy_len;
    busy_q && !busy && !rst_q |-> (bcnt_q > ERASE_CYCLES - 4 && bcnt_q < ERASE_CYCLES + 4)
      || (bcnt_q > PROG_CYCLES - 4 && bcnt_q < PROG_CYCLES + 4);
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy run length wrong");
  property p_rst_len;
    busy_q && !busy && rst_q |-> bcnt_q > SSR_RST_CYCLES - 8 && bcnt_q < SSR_RST_CYCLES + 8;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset interval length wrong");
  property p_rst_busy;
    sw_reset |-> ##[0:4] busy;
  endproperty
  a_rst_busy: assert property (p_rst_busy) else $error("reset not busy");
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// Testbench: APB-driven controller joined to the flash end by the link.
// Assumes both ends and the checker share pclk and presetn.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ssr_pkg::*;
  localparam int ERASE_N = 1000;
  localparam int PROG_N = 20;
  localparam int SCK_H = 8;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr, a;
  logic [31:0] pwdata, prdata, q, d, seed;
  logic [2:0] otp_lock_bits;
  logic write_enable_latch, ext_busy, busy, wel_clear, sw_reset, oe_seen;
  logic [7:0] mem [3][256];
  logic [7:0] pa [3];
  int n_fail, comparisons, n_rst, cyc;
  ssr_link_if link ();
  ssr_flash_dev #(.ERASE_CYCLES(ERASE_N), .PROG_CYCLES(PROG_N)) ssr_flash_dev_i (
    .pclk(pclk), .presetn(presetn), .link(link.dev), .otp_lock_bits(otp_lock_bits),
    .write_enable_latch(write_enable_latch), .ext_busy(ext_busy), .busy(busy),
    .wel_clear(wel_clear), .sw_reset(sw_reset));
  ssr_host_ctrl #(.SCK_HALF(SCK_H)) ssr_host_ctrl_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link(link.host));
  ssr_link_monitor #(.ERASE_CYCLES(ERASE_N), .PROG_CYCLES(PROG_N)) ssr_link_monitor_i (
    .pclk(pclk), .presetn(presetn), .cs_n(link.cs_n), .sck(link.sck), .mosi(link.mosi),
    .miso(link.miso), .miso_oe(link.miso_oe), .busy(busy), .wel_clear(wel_clear),
    .sw_reset(sw_reset));

  // ==========================================================
  // Clock, status latch, event counters and watchdog
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (wel_clear === 1'b1) write_enable_latch <= 1'b0;
    if (sw_reset === 1'b1) n_rst++;
    if (link.miso_oe === 1'b1) oe_seen <= 1'b1;
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      finish_test();
    end
  end

  // ==========================================================
  // Tasks and expectation functions
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [23:0] ra(input int s, input logic [7:0] b);
    return {SSR_ADDR_HI, (s == 0) ? SSR_SEL1 : (s == 1) ? SSR_SEL2 : SSR_SEL3, SSR_ADDR_MID, b};
  endfunction
  function automatic logic [31:0] exp4(input int s, input logic [7:0] b);
    return {mem[s][b], mem[s][8'(b + 8'h1)], mem[s][8'(b + 8'h2)], mem[s][8'(b + 8'h3)]};
  endfunction
  task automatic frame(input logic [7:0] op, input logic [23:0] ad, input logic [2:0] nb,
                       input logic sa, input logic dm, input logic [31:0] tx);
    apb(1'b1, SSR_R_ADDR, {8'h00, ad});
    apb(1'b1, SSR_R_TXD, tx);
    apb(1'b1, SSR_R_CTRL, {1'b1, 16'h0000, 1'b0, nb, dm, sa, 1'b1, op});
    q = 32'h1;
    while (q[0] !== 1'b0) apb(1'b0, SSR_R_STAT, 32'h0);
    repeat (2 * SCK_H) @(posedge pclk);
  endtask
  task automatic wait_dev();
    while (busy === 1'b1) @(posedge pclk);
    @(posedge pclk);
  endtask
  task automatic erase(input int s, input logic [2:0] nb, input logic we);
    write_enable_latch <= we;
    frame(SSR_OP_ERASE, ra(s, 8'h00), nb, 1'b1, 1'b0, 32'h0);
    wait_dev();
    if (we && nb == 3'h0 && !otp_lock_bits[s]) for (int i = 0; i < 256; i++) mem[s][i] = 8'hff;
  endtask
  task automatic prog(input int s, input logic [7:0] b, input logic we);
    d = $random(seed);
    write_enable_latch <= we;
    frame(SSR_OP_PROG, ra(s, b), 3'h4, 1'b1, 1'b0, d);
    wait_dev();
    if (we && !otp_lock_bits[s]) for (int i = 0; i < 4; i++) mem[s][b + i] = d[31 - 8 * i -: 8];
  endtask
  task automatic rd(input int s, input logic [7:0] b);
    frame(SSR_OP_READ, ra(s, b), 3'h4, 1'b1, 1'b1, 32'h0);
    apb(1'b0, SSR_R_RXD, 32'h0);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'he92d;
    n_fail = 0;
    comparisons = 0;
    n_rst = 0;
    cyc = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    otp_lock_bits = 3'h0;
    write_enable_latch = 1'b0;
    ext_busy = 1'b0;
    oe_seen = 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h20, 32'h0);
    chk({e, q[30:0]}, 32'h8000_0000);
    for (int s = 0; s < 3; s++) begin
      erase(s, 3'h0, 1'b1);
      chk({31'h0, write_enable_latch}, 32'h0);
      a = 8'($random(seed));
      rd(s, a);
      chk(q, exp4(s, a));
    end
    for (int s = 0; s < 3; s++) begin
      pa[s] = 8'h20 + (8'($random(seed)) & 8'h70);
      prog(s, pa[s], 1'b1);
      prog(s, pa[s] + 8'h4, 1'b0);
      rd(s, pa[s]);
      chk(q, exp4(s, pa[s]));
      rd(s, pa[s] + 8'h4);
      chk(q, exp4(s, pa[s] + 8'h4));
    end
    rd(1, pa[0]);
    chk(q, exp4(1, pa[0]));
    prog(0, 8'hfc, 1'b1);
    prog(0, 8'h00, 1'b1);
    rd(0, 8'hfe);
    chk(q, exp4(0, 8'hfe));
    erase(1, 3'h0, 1'b0);
    rd(1, pa[1]);
    chk(q, exp4(1, pa[1]));
    erase(2, 3'h1, 1'b1);
    rd(2, pa[2]);
    chk(q, exp4(2, pa[2]));
    otp_lock_bits <= 3'h2;
    erase(1, 3'h0, 1'b1);
    rd(1, pa[1]);
    chk(q, exp4(1, pa[1]));
    prog(1, pa[1] + 8'h8, 1'b1);
    rd(1, pa[1] + 8'h8);
    chk(q, exp4(1, pa[1] + 8'h8));
    write_enable_latch <= 1'b1;
    frame(SSR_OP_ERASE, ra(2, 8'h00), 3'h0, 1'b1, 1'b0, 32'h0);
    oe_seen <= 1'b0;
    rd(2, 8'h00);
    chk({31'h0, oe_seen}, 32'h0);
    wait_dev();
    for (int i = 0; i < 256; i++) mem[2][i] = 8'hff;
    rd(2, pa[2]);
    chk(q, exp4(2, pa[2]));
    ext_busy <= 1'b1;
    oe_seen <= 1'b0;
    rd(0, 8'h00);
    chk({31'h0, oe_seen}, 32'h0);
    ext_busy <= 1'b0;
    wait_dev();
    write_enable_latch <= 1'b1;
    frame(SSR_OP_RST_EN, 24'h0, 3'h0, 1'b0, 1'b0, 32'h0);
    frame(SSR_OP_RST, 24'h0, 3'h0, 1'b0, 1'b0, 32'h0);
    chk(32'(n_rst), 32'h1);
    chk({31'h0, write_enable_latch}, 32'h0);
    oe_seen <= 1'b0;
    rd(0, 8'hfe);
    chk({31'h0, oe_seen}, 32'h0);
    wait_dev();
    rd(0, 8'hfe);
    chk(q, exp4(0, 8'hfe));
    for (int k = 0; k < 3; k++) begin
      d = $random(seed);
      if (k == 0 || d[7:0] == SSR_OP_RST_EN || d[7:0] == SSR_OP_RST) d[7:0] = SSR_OP_READ;
      frame(SSR_OP_RST_EN, 24'h0, 3'h0, 1'b0, 1'b0, 32'h0);
      frame(d[7:0], 24'h0, 3'h0, 1'b0, 1'b0, 32'h0);
      frame(SSR_OP_RST, 24'h0, 3'h0, 1'b0, 1'b0, 32'h0);
    end
    chk(32'(n_rst), 32'h1);
    finish_test();
  end
endmodule
`default_nettype wire
